// ### eba_defines.svh
`ifndef EBA_DEFINES_SVH
`define EBA_DEFINES_SVH

// ****************************************
// Buffer geometry
// ****************************************
`define EBA_EVENTS          32
`define EBA_SLOT_WORDS      34
`define EBA_MEM_WORDS       1088
`define EBA_WIN_LAST        16'h07fc
`define EBA_FIFO_DEPTH      8

// ****************************************
// Word layout
// ****************************************
`define EBA_TYPE_MSB        26
`define EBA_TYPE_LSB        24
`define EBA_TYPE_DATA       3'h0
`define EBA_TYPE_HEADER     3'h2
`define EBA_TYPE_EOE        3'h4
`define EBA_CHAN_LSB        16
`define EBA_BELOW_BIT       13
`define EBA_OVF_BIT         12
`define EBA_HDR_CNT_LSB     8

// ****************************************
// Timing
// ****************************************
`define EBA_CLK_NS          25
`define EBA_HOLDOFF_NS      600
`define EBA_HOLDOFF_CYC     ((`EBA_HOLDOFF_NS + `EBA_CLK_NS - 1) / `EBA_CLK_NS)

`endif

// ### eba_pkg.sv
`default_nettype none
package eba_pkg;

  typedef struct packed {
    logic [4:0]  channel;
    logic [11:0] value;
    logic        overflow;
    logic        below;
    logic        last;
  } eba_sample_s;

  typedef enum logic [2:0] {
    EBA_IDLE,
    EBA_CONV,
    EBA_DRAIN,
    EBA_HDR,
    EBA_EOE
  } eba_state_e;

endpackage
`default_nettype wire

// ### eba_top.sv
// Summary of operation
// - Overflowed values dropped by default.
// - Overflow store enable keeps them, bit 12.
// - Dual-port buffer, 32 events, 34 words each.
// - Write pointer advances after channel conversion.
// - Read pointer auto-advances when enabled.
// - Dummy writes advance event or word.
// - Any window read returns pointed word.
// - Not empty when event indexes differ.
// - Equal pointers: last increment decides full/empty.
// - Event is header, data words, end word.
// - Empty events stored only when enabled.
// - 24-bit gate pulse counter.
// - Count all gates or only accepted ones.
// - Count in end word and two outputs.
// - Busy sources drive busy and status bits.
// - Busy after gate edge; gates ignored meanwhile.
// - Strap picks board-wide or own busy stop.
// - Data reset clears buffer, pointers, counter, integrators.
// - Software reset adds register clear.
// - Hardware reset does everything.
// - Fast abort inside window aborts conversion.
// - No gate until 600 ns after abort.
// - Below-threshold values dropped or flagged bit 13.
`include "eba_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Data FIFO
// ****************************************
module eba_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = store[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ****************************************
// Acquisition control top
// ****************************************
module eba_top (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 gate,
  input  wire logic                 conversion_inhibit,
  input  wire logic                 fast_abort,
  input  wire logic                 front_reset,
  input  wire logic [15:0]          fast_clear_window,
  input  wire logic                 busy_line_in,
  input  wire logic                 stop_on_any_board_busy,
  input  wire logic                 overflow_store_enable,
  input  wire logic                 store_below_threshold,
  input  wire logic                 store_empty_events,
  input  wire logic                 read_pointer_auto_advance,
  input  wire logic                 count_every_gate,
  input  wire logic                 data_clear_request,
  input  wire logic                 register_reset_hold,
  input  wire logic                 single_shot_reset,
  input  wire logic                 front_reset_scope_select,
  input  wire logic                 memory_test_mode,
  input  wire eba_pkg::eba_sample_s conv_sample,
  input  wire logic                 conv_valid,
  output logic                      conv_ready,
  output logic                      conv_start,
  output logic                      conv_abort,
  output logic                      integrator_reset,
  output logic                      register_clear,
  output logic                      register_clear_all,
  input  wire logic                 host_rd,
  input  wire logic [15:0]          host_addr,
  input  wire logic                 host_wr_event_adv,
  input  wire logic                 host_wr_word_adv,
  output logic [31:0]               host_rd_data,
  output logic                      host_rd_valid,
  output logic                      busy_out,
  output logic                      status_busy,
  output logic                      status_global_busy,
  output logic                      buf_full,
  output logic                      buf_empty,
  output logic                      buf_not_empty,
  output logic [15:0]               gate_count_low,
  output logic [7:0]                gate_count_high
);
  import eba_pkg::*;

  // Base word of an event slot, 34 words per slot.
  function automatic logic [10:0] slot_base(input logic [4:0] ev);
    slot_base = {1'b0, ev, 5'h00} + {5'h00, ev, 1'b0};
  endfunction

  // ****************************************
  // Resets
  // ****************************************
  logic soft_reset;
  logic data_reset;

  assign soft_reset = rst | register_reset_hold | single_shot_reset
                    | (front_reset & front_reset_scope_select);
  assign data_reset = soft_reset | data_clear_request
                    | (front_reset & ~front_reset_scope_select);
  assign integrator_reset   = data_reset;
  assign register_clear     = soft_reset;
  assign register_clear_all = rst;

  // ****************************************
  // Busy and gate acceptance
  // ****************************************
  eba_state_e state_r;
  logic       strap_any_r;
  logic       gate_d_r;
  logic       abort_d_r;
  logic       gate_edge;
  logic       abort_edge;
  logic       own_busy;
  logic       stop_acq;
  logic [5:0] holdoff_r;
  logic       gate_ok;
  logic       gate_take;
  logic [15:0] win_cnt_r;
  logic       in_window;
  logic       abort_take;
  logic       full_w;

  // The strap is caught while reset is held, so it can never change mid-run.
  always_ff @(posedge clock) begin
    if (rst) begin
      strap_any_r <= stop_on_any_board_busy;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      gate_d_r  <= 1'b0;
      abort_d_r <= 1'b0;
    end else begin
      gate_d_r  <= gate;
      abort_d_r <= fast_abort;
    end
  end

  assign gate_edge  = gate & ~gate_d_r;
  assign abort_edge = fast_abort & ~abort_d_r;
  assign own_busy   = (state_r != EBA_IDLE) | data_reset | full_w | memory_test_mode;
  assign stop_acq   = strap_any_r ? (own_busy | busy_line_in) : own_busy;
  assign gate_ok    = ~stop_acq & ~conversion_inhibit & ~fast_abort & (holdoff_r == '0);
  assign gate_take  = gate_edge & gate_ok;
  assign in_window  = (win_cnt_r < fast_clear_window);
  assign abort_take = abort_edge & in_window
                    & ((state_r == EBA_CONV) | (state_r == EBA_DRAIN));

  assign busy_out           = own_busy;
  assign status_busy        = own_busy;
  assign status_global_busy = own_busy | busy_line_in;

  always_ff @(posedge clock) begin
    if (data_reset) begin
      holdoff_r <= '0;
    end else if (abort_take) begin
      holdoff_r <= 6'(`EBA_HOLDOFF_CYC);
    end else if (holdoff_r != '0) begin
      holdoff_r <= holdoff_r - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (data_reset || gate_take) begin
      win_cnt_r <= '0;
    end else if (state_r != EBA_IDLE && in_window) begin
      win_cnt_r <= win_cnt_r + 1'b1;
    end
  end

  // ****************************************
  // Gate counter
  // ****************************************
  logic [23:0] gate_cnt_r;

  always_ff @(posedge clock) begin
    if (data_reset) begin
      gate_cnt_r <= '0;
    end else if (gate_edge && (count_every_gate || gate_ok)) begin
      gate_cnt_r <= gate_cnt_r + 1'b1;
    end
  end

  assign gate_count_low  = gate_cnt_r[15:0];
  assign gate_count_high = gate_cnt_r[23:16];

  // ****************************************
  // Sample filter and FIFO
  // ****************************************
  logic        keep;
  logic [31:0] data_word;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [31:0] fifo_out_data;
  logic        collecting;

  assign collecting = (state_r == EBA_CONV);
  assign keep = ~(conv_sample.overflow & ~overflow_store_enable)
              & ~(conv_sample.below & ~store_below_threshold);

  always_comb begin
    data_word = '0;
    data_word[`EBA_TYPE_MSB:`EBA_TYPE_LSB] = `EBA_TYPE_DATA;
    data_word[`EBA_CHAN_LSB +: 5] = conv_sample.channel;
    data_word[`EBA_BELOW_BIT]     = conv_sample.below;
    data_word[`EBA_OVF_BIT]       = conv_sample.overflow;
    data_word[11:0]               = conv_sample.value;
  end

  // Samples stall the converter when the FIFO fills, so none are lost.
  assign conv_ready = collecting & fifo_in_ready;

  eba_fifo #(
    .WIDTH (32),
    .DEPTH (`EBA_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (data_reset),
    .flush     (abort_take),
    .in_valid  (conv_valid & collecting & keep),
    .in_ready  (fifo_in_ready),
    .in_data   (data_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ****************************************
  // Event writer
  // ****************************************
  logic [31:0] mem [`EBA_MEM_WORDS];
  logic [5:0]  ev_len [`EBA_EVENTS];
  logic [4:0]  wr_ev_r;
  logic [5:0]  nwords_r;
  logic        mem_we;
  logic [10:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic        wr_inc;
  logic        seen_last_r;

  assign fifo_out_ready = (state_r == EBA_CONV) | (state_r == EBA_DRAIN);

  always_ff @(posedge clock) begin
    if (data_reset || abort_take) begin
      state_r <= EBA_IDLE;
    end else begin
      unique case (state_r)
        EBA_IDLE: begin
          if (gate_take) begin
            state_r <= EBA_CONV;
          end
        end
        EBA_CONV: begin
          if (conv_valid && conv_ready && conv_sample.last) begin
            state_r <= EBA_DRAIN;
          end
        end
        EBA_DRAIN: begin
          if (!fifo_out_valid) begin
            if (nwords_r != '0 || store_empty_events) begin
              state_r <= EBA_HDR;
            end else begin
              state_r <= EBA_IDLE;
            end
          end
        end
        EBA_HDR: begin
          state_r <= EBA_EOE;
        end
        EBA_EOE: begin
          state_r <= EBA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (data_reset || gate_take || abort_take) begin
      nwords_r <= '0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      nwords_r <= nwords_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      seen_last_r <= 1'b0;
    end else begin
      seen_last_r <= (state_r == EBA_DRAIN);
    end
  end

  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = slot_base(wr_ev_r);
    mem_wdata = '0;
    if (fifo_out_valid && fifo_out_ready) begin
      mem_we    = 1'b1;
      mem_waddr = slot_base(wr_ev_r) + 11'(nwords_r) + 11'h001;
      mem_wdata = fifo_out_data;
    end else if (state_r == EBA_HDR) begin
      mem_we    = 1'b1;
      mem_wdata[`EBA_TYPE_MSB:`EBA_TYPE_LSB] = `EBA_TYPE_HEADER;
      mem_wdata[`EBA_HDR_CNT_LSB +: 6]       = nwords_r;
    end else if (state_r == EBA_EOE) begin
      mem_we    = 1'b1;
      mem_waddr = slot_base(wr_ev_r) + 11'(nwords_r) + 11'h001;
      mem_wdata[`EBA_TYPE_MSB:`EBA_TYPE_LSB] = `EBA_TYPE_EOE;
      mem_wdata[23:0] = gate_cnt_r;
    end
  end

  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  assign wr_inc = (state_r == EBA_EOE);

  always_ff @(posedge clock) begin
    if (wr_inc) begin
      ev_len[wr_ev_r] <= nwords_r + 6'h02;
    end
  end

  always_ff @(posedge clock) begin
    if (data_reset) begin
      wr_ev_r <= '0;
    end else if (wr_inc) begin
      wr_ev_r <= wr_ev_r + 1'b1;
    end
  end

  // ****************************************
  // Read side
  // ****************************************
  logic [4:0] rd_ev_r;
  logic [5:0] rd_word_r;
  logic       last_was_wr_r;
  logic       rd_hit;
  logic       word_step;
  logic       ev_step;
  logic       rd_inc;

  assign rd_hit    = host_rd & (host_addr <= `EBA_WIN_LAST);
  assign word_step = host_wr_word_adv | (rd_hit & read_pointer_auto_advance);
  assign ev_step   = host_wr_event_adv
                   | (word_step && (rd_word_r + 6'h01 >= ev_len[rd_ev_r]));
  // Stepping an empty buffer would lap the writer, so it is held.
  assign rd_inc    = ev_step & ~buf_empty;

  always_ff @(posedge clock) begin
    if (data_reset) begin
      rd_ev_r   <= '0;
      rd_word_r <= '0;
    end else if (rd_inc) begin
      rd_ev_r   <= rd_ev_r + 1'b1;
      rd_word_r <= '0;
    end else if (word_step && !buf_empty) begin
      rd_word_r <= rd_word_r + 1'b1;
    end
  end

  // The write increment wins a tie so a filled buffer is never seen as empty.
  always_ff @(posedge clock) begin
    if (data_reset) begin
      last_was_wr_r <= 1'b0;
    end else if (wr_inc) begin
      last_was_wr_r <= 1'b1;
    end else if (rd_inc) begin
      last_was_wr_r <= 1'b0;
    end
  end

  assign buf_not_empty = (rd_ev_r != wr_ev_r);
  assign full_w        = ~buf_not_empty & last_was_wr_r;
  assign buf_full      = full_w;
  assign buf_empty     = ~buf_not_empty & ~last_was_wr_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      host_rd_data  <= '0;
      host_rd_valid <= 1'b0;
    end else begin
      host_rd_valid <= host_rd;
      if (rd_hit) begin
        host_rd_data <= mem[slot_base(rd_ev_r) + 11'(rd_word_r)];
      end else if (host_rd) begin
        host_rd_data <= '0;
      end
    end
  end

  // ****************************************
  // Converter control
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
    end else begin
      conv_start <= gate_take;
      conv_abort <= abort_take;
    end
  end

endmodule
`default_nettype wire

// ### eba_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Converter side model
// ****************************************
module eba_conv_model (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          conv_start,
  input  wire logic          conv_abort,
  input  wire logic          conv_ready,
  input  wire logic [5:0]    nsamp,
  input  wire logic [31:0]   ovf_mask,
  input  wire logic [7:0]    lag,
  output eba_pkg::eba_sample_s conv_sample,
  output logic               conv_valid
);
  import eba_pkg::*;
  int   idx;
  int   wait_c;
  logic act_r;
  logic tg_r = 1'b0;
  logic last_w;
  assign last_w = (idx == int'(nsamp) - 1);
  assign conv_valid = act_r && (wait_c == 0);
  // Idle data toggles every cycle, so a stale sample can never pass for a fresh one.
  assign conv_sample = conv_valid ? eba_sample_s'{idx[4:0], 12'h100 + idx[11:0], ovf_mask[idx[4:0]], 1'b0, last_w}
                                  : eba_sample_s'({21{tg_r}});
  always @(posedge clock) begin
    tg_r <= ~tg_r;
    if (rst || conv_abort) begin
      act_r <= 1'b0;
    end else if (conv_start) begin
      act_r <= 1'b1;
      idx <= 0;
      wait_c <= int'(lag);
    end else if (act_r && wait_c != 0) begin
      wait_c <= wait_c - 1;
    end else if (conv_valid && conv_ready) begin
      idx <= idx + 1;
      if (last_w) begin
        act_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### eba_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module eba_top_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        gate,
  input wire logic        busy_line_in,
  input wire logic        count_every_gate,
  input wire logic        conv_start,
  input wire logic        conv_abort,
  input wire logic        integrator_reset,
  input wire logic        host_rd,
  input wire logic [15:0] host_addr,
  input wire logic [31:0] host_rd_data,
  input wire logic        host_rd_valid,
  input wire logic        busy_out,
  input wire logic        status_busy,
  input wire logic        status_global_busy,
  input wire logic        buf_full,
  input wire logic        buf_empty,
  input wire logic        buf_not_empty,
  input wire logic [15:0] gate_count_low,
  input wire logic [7:0]  gate_count_high
);
  logic [23:0] cnt;
  logic [5:0]  since_r;
  assign cnt = {gate_count_high, gate_count_low};
  // Saturates so that a long idle stretch never wraps back into the hold-off range.
  always_ff @(posedge clock) begin
    if (rst) begin
      since_r <= 6'h3f;
    end else if (conv_abort) begin
      since_r <= 6'h00;
    end else if (since_r != 6'h3f) begin
      since_r <= since_r + 6'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  start_busy_a: assert property (conv_start |-> busy_out)
    else $error("start without busy");
  read_answer_a: assert property (host_rd |=> host_rd_valid)
    else $error("read not answered");
  out_window_a: assert property (host_rd && host_addr > 16'h07fc |=> host_rd_data == 32'h0)
    else $error("read outside window not zero");
  buf_state_a: assert property ($onehot({buf_full, buf_empty, buf_not_empty}))
    else $error("buffer status not one-hot");
  full_busy_a: assert property (buf_full |-> busy_out && status_busy)
    else $error("full without busy");
  global_busy_a: assert property (status_global_busy == (status_busy || busy_line_in))
    else $error("global busy wrong");
  gate_count_a: assert property ($rose(gate) && count_every_gate && !integrator_reset ##1 !integrator_reset
    |-> ##[0:1] (cnt != $past(cnt))) else $error("gate not counted");
  clear_a: assert property (integrator_reset |=> cnt == 24'h0 && buf_empty)
    else $error("data reset incomplete");
  holdoff_a: assert property (conv_start |-> since_r >= 6'd23)
    else $error("gate accepted inside hold-off");
endmodule
bind eba_top eba_top_chk u_chk (.clock, .rst, .gate, .busy_line_in, .count_every_gate, .conv_start, .conv_abort,
  .integrator_reset, .host_rd, .host_addr, .host_rd_data, .host_rd_valid, .busy_out, .status_busy,
  .status_global_busy, .buf_full, .buf_empty, .buf_not_empty, .gate_count_low, .gate_count_high);
`default_nettype wire

// ### eba_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Testbench
// ****************************************
module eba_top_bench;
  import eba_pkg::*;
  logic clock, rst, gate, conversion_inhibit, fast_abort, front_reset, busy_line_in, stop_on_any_board_busy;
  logic overflow_store_enable, store_below_threshold, store_empty_events, read_pointer_auto_advance;
  logic count_every_gate, data_clear_request, register_reset_hold, single_shot_reset;
  logic front_reset_scope_select, memory_test_mode, conv_valid, conv_ready, conv_start, conv_abort;
  logic integrator_reset, register_clear, register_clear_all, host_rd, host_wr_event_adv, host_wr_word_adv;
  logic host_rd_valid, busy_out, status_busy, status_global_busy, buf_full, buf_empty, buf_not_empty;
  logic [15:0] fast_clear_window, host_addr, gate_count_low;
  logic [31:0] host_rd_data, ovf_mask;
  logic [7:0]  gate_count_high, lag;
  logic [5:0]  nsamp;
  eba_sample_s conv_sample;
  int          err_total = 0;
  int          checks_done = 0;

  eba_top DUT (.clock, .rst, .gate, .conversion_inhibit, .fast_abort, .front_reset, .fast_clear_window,
    .busy_line_in, .stop_on_any_board_busy, .overflow_store_enable, .store_below_threshold, .store_empty_events,
    .read_pointer_auto_advance, .count_every_gate, .data_clear_request, .register_reset_hold, .single_shot_reset,
    .front_reset_scope_select, .memory_test_mode, .conv_sample, .conv_valid, .conv_ready, .conv_start,
    .conv_abort, .integrator_reset, .register_clear, .register_clear_all, .host_rd, .host_addr,
    .host_wr_event_adv, .host_wr_word_adv, .host_rd_data, .host_rd_valid, .busy_out, .status_busy,
    .status_global_busy, .buf_full, .buf_empty, .buf_not_empty, .gate_count_low, .gate_count_high);
  eba_conv_model u_conv (.clock, .rst, .conv_start, .conv_abort, .conv_ready, .nsamp, .ovf_mask, .lag,
    .conv_sample, .conv_valid);

  always #12.5 clock = ~clock;

  task automatic results();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  function automatic logic [31:0] hdr(input int n);
    return 32'h0200_0000 | (n << 8);
  endfunction
  function automatic logic [31:0] dat(input int ch, input int ov);
    return (ch << 16) | (ov << 12) | (32'h100 + ch);
  endfunction
  function automatic logic [31:0] eoe(input int c);
    return 32'h0400_0000 | c;
  endfunction
  // One read strobe; the answer is taken in the cycle after the strobe.
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    host_addr = a;
    host_rd = 1'b1;
    tick(1);
    chk(host_rd_valid, 1);
    chk(host_rd_data, exp);
    host_rd = 1'b0;
    tick(1);
  endtask
  task automatic adv(input logic ev_step);
    host_wr_event_adv = ev_step;
    host_wr_word_adv = ~ev_step;
    tick(1);
    host_wr_event_adv = 1'b0;
    host_wr_word_adv = 1'b0;
    tick(1);
  endtask
  // Gate pulse, optional abort ab cycles later, then a bounded wait for busy to fall.
  task automatic ev(input int n, input logic [31:0] m, input int lg, input int ab);
    nsamp = 6'(n);
    ovf_mask = m;
    lag = 8'(lg);
    gate = 1'b1;
    tick(2);
    gate = 1'b0;
    if (ab != 0) begin
      tick(ab);
      fast_abort = 1'b1;
      tick(2);
      fast_abort = 1'b0;
    end
    for (int i = 0; i < 300 && busy_out !== 1'b0; i++) begin
      tick(1);
    end
    tick(1);
  endtask
  task automatic done(input int t);
    $display("test %0d finished", t);
  endtask

  initial begin
    #(25 * 20000);
    err_total++;
    results();
  end

  initial begin
    {clock, gate, conversion_inhibit, fast_abort, front_reset, busy_line_in, stop_on_any_board_busy} = '0;
    {overflow_store_enable, store_below_threshold, store_empty_events, read_pointer_auto_advance} = '0;
    {data_clear_request, register_reset_hold, single_shot_reset, front_reset_scope_select} = '0;
    {memory_test_mode, host_rd, host_wr_event_adv, host_wr_word_adv} = '0;
    {host_addr, nsamp, ovf_mask, lag} = '0;
    count_every_gate = 1'b1;
    fast_clear_window = 16'h0010;
    rst = 1'b1;
    tick(16);
    chk(register_clear_all, 1);
    chk(buf_empty, 1);
    rst = 1'b0;
    tick(2);
    ev(3, 32'h2, 0, 0);
    chk(buf_not_empty, 1);
    chk(gate_count_low, 1);
    rd(16'h0000, hdr(2));
    rd(16'h0400, hdr(2));
    rd(16'h0800, 32'h0);
    adv(0);
    rd(16'h0004, dat(0, 0));
    adv(0);
    rd(16'h0008, dat(2, 0));
    adv(0);
    rd(16'h000c, eoe(1));
    adv(1);
    chk(buf_empty, 1);
    done(1);
    overflow_store_enable = 1'b1;
    read_pointer_auto_advance = 1'b1;
    ev(2, 32'h1, 0, 0);
    rd(16'h07fc, hdr(2));
    rd(16'h0000, dat(0, 1));
    rd(16'h0100, dat(1, 0));
    rd(16'h0000, eoe(2));
    chk(buf_empty, 1);
    done(2);
    overflow_store_enable = 1'b0;
    ev(2, 32'h3, 0, 0);
    chk(buf_empty, 1);
    store_empty_events = 1'b1;
    ev(1, 32'h1, 0, 0);
    rd(16'h0000, hdr(0));
    rd(16'h0000, eoe(4));
    store_empty_events = 1'b0;
    read_pointer_auto_advance = 1'b0;
    done(3);
    count_every_gate = 1'b0;
    for (int i = 0; i < 32; i++) begin
      ev(1, 32'h0, 0, 0);
    end
    chk(buf_full, 1);
    chk(busy_out, 1);
    ev(1, 32'h0, 0, 0);
    chk({gate_count_high, gate_count_low}, 24'd36);
    count_every_gate = 1'b1;
    ev(1, 32'h0, 0, 0);
    chk({gate_count_high, gate_count_low}, 24'd37);
    adv(1);
    chk(buf_not_empty, 1);
    data_clear_request = 1'b1;
    tick(2);
    data_clear_request = 1'b0;
    tick(1);
    chk(buf_empty, 1);
    chk({gate_count_high, gate_count_low}, 24'd0);
    done(4);
    read_pointer_auto_advance = 1'b1;
    ev(1, 32'h0, 20, 2);
    chk(buf_empty, 1);
    ev(1, 32'h0, 0, 0);
    chk(buf_empty, 1);
    tick(30);
    ev(1, 32'h0, 0, 0);
    rd(16'h0000, hdr(1));
    rd(16'h0000, dat(0, 0));
    rd(16'h0000, eoe(3));
    fast_clear_window = 16'h0002;
    ev(1, 32'h0, 20, 6);
    rd(16'h0000, hdr(1));
    rd(16'h0000, dat(0, 0));
    rd(16'h0000, eoe(4));
    done(5);
    memory_test_mode = 1'b1;
    busy_line_in = 1'b1;
    tick(2);
    chk(status_busy, 1);
    chk(status_global_busy, 1);
    memory_test_mode = 1'b0;
    busy_line_in = 1'b0;
    front_reset = 1'b1;
    tick(1);
    chk(integrator_reset, 1);
    chk(register_clear, 0);
    front_reset_scope_select = 1'b1;
    tick(1);
    chk(register_clear, 1);
    {front_reset, front_reset_scope_select, register_reset_hold} = 3'b001;
    tick(3);
    chk(register_clear, 1);
    {register_reset_hold, single_shot_reset} = 2'b01;
    tick(1);
    chk(register_clear, 1);
    single_shot_reset = 1'b0;
    tick(1);
    chk(register_clear, 0);
    done(6);
    stop_on_any_board_busy = 1'b1;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(2);
    busy_line_in = 1'b1;
    ev(1, 32'h0, 0, 0);
    chk(buf_empty, 1);
    busy_line_in = 1'b0;
    ev(1, 32'h0, 0, 0);
    chk(buf_not_empty, 1);
    done(7);
    results();
  end
endmodule
`default_nettype wire
